// ===== logic/idp_consts.svh
// offsets, field values and reset values of the identify page block
`ifndef IDP_CONSTS_SVH
`define IDP_CONSTS_SVH
// ---------------------------------------------------------------
// command and page layout
// ---------------------------------------------------------------
`define IDP_CMD_IDENTIFY 8'hEC
`define IDP_PAGE_LAST 8'hFF
`define IDP_W_GENCFG 16'h044A
`define IDP_W_MULTMAX 16'h8001
`define IDP_W_CAPAB 16'h0B00
`define IDP_W_PIOTIM 16'h0200
`define IDP_W_VALID 16'h0007
`define IDP_W_MULT_VALID 8'h01
`define IDP_W_DMA_SUPP 8'h07
`define IDP_W_APIO 16'h0003
`define IDP_CYCLE_NS 16'h0078
`define IDP_W_MAJOR 16'h00FE
`define IDP_W_MINOR 16'h0021
`define IDP_W_FEAT82 16'h706B
`define IDP_W_FEAT83 16'h7408
`define IDP_W_FEAT84 16'h4000
`define IDP_W_UDMA 16'h007F
`define IDP_W_APM 16'h0000
`define IDP_W_ROTATE 16'h0001
`define IDP_SIGNATURE 8'hA5
`define IDP_SPACES 16'h2020
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IDP_OFF_STATUS 8'h00
`define IDP_OFF_DEFCYL 8'h04
`define IDP_OFF_DEFHEAD 8'h08
`define IDP_OFF_DEFSPT 8'h0C
`define IDP_OFF_CURCYL 8'h10
`define IDP_OFF_CURHEAD 8'h14
`define IDP_OFF_CURSPT 8'h18
`define IDP_OFF_TOTSEC 8'h1C
`define IDP_OFF_MODE 8'h20
`define IDP_OFF_SER0 8'h24
`define IDP_OFF_SER1 8'h28
`define IDP_OFF_SER2 8'h2C
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IDP_RST_CYL 16'h0100
`define IDP_RST_HEAD 16'h0010
`define IDP_RST_SPT 16'h0020
`define IDP_RST_TOTSEC 32'h0008_0000
`define IDP_RST_SERIAL 80'h3030_3030_3030_3030_3030
`endif

// ===== logic/idp_pkg.sv
// types of the identify page block
`default_nettype none
package idp_pkg;
  typedef enum logic [1:0] {
    IDP_IDLE = 2'b00,
    IDP_LOAD = 2'b01,
    IDP_XFER = 2'b11
  } idp_state_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } idp_wb_req_s;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } idp_wb_rsp_s;
endpackage
`default_nettype wire

// ===== logic/idp_identify_page.sv
// identify parameter page generator with wishbone configuration slave
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "idp_consts.svh"
module idp_identify_page #(
  parameter logic [79:0] UNIQUE_ID = 80'h3132_3334_3536_3738_3930, // arbitrary value
  parameter logic [63:0] FW_REV = 64'h3130_3030_2020_2020 // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // wishbone slave
  input wire idp_pkg::idp_wb_req_s wbReq,
  output var idp_pkg::idp_wb_rsp_s wbRsp,
  // ata command and data register side
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic dataRead,
  output logic drq,
  output logic busy,
  output logic [15:0] dataOut
);
  import idp_pkg::*;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [15:0] defCyl_reg, defHead_reg, defSpt_reg;
  logic [15:0] curCyl_reg, curHead_reg, curSpt_reg;
  logic [31:0] totSec_reg;
  logic [7:0] multCnt_reg;
  logic [1:0] dmaSel_reg;
  logic [79:0] userSer_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  idp_state_e state_reg;
  logic [7:0] idx_reg;
  logic [7:0] sum_reg;
  logic [15:0] data_reg;
  logic wbWr;
  logic [31:0] capacity;

  function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // byte merge for the 16-bit registers
  function automatic logic [15:0] wbMerge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  assign wbWr = wbReq.cyc && wbReq.stb && wbReq.we && !ack_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      defCyl_reg <= `IDP_RST_CYL;
      defHead_reg <= `IDP_RST_HEAD;
      defSpt_reg <= `IDP_RST_SPT;
      curCyl_reg <= `IDP_RST_CYL;
      curHead_reg <= `IDP_RST_HEAD;
      curSpt_reg <= `IDP_RST_SPT;
      totSec_reg <= `IDP_RST_TOTSEC;
      multCnt_reg <= 8'h00;
      dmaSel_reg <= 2'h0;
      userSer_reg <= `IDP_RST_SERIAL;
    end else if (wbWr) begin
      case (wbReq.adr)
        `IDP_OFF_DEFCYL: defCyl_reg <= wbMerge16(defCyl_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_DEFHEAD: defHead_reg <= wbMerge16(defHead_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_DEFSPT: defSpt_reg <= wbMerge16(defSpt_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_CURCYL: curCyl_reg <= wbMerge16(curCyl_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_CURHEAD: curHead_reg <= wbMerge16(curHead_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_CURSPT: curSpt_reg <= wbMerge16(curSpt_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_TOTSEC: totSec_reg <= wbMerge(totSec_reg, wbReq.dat, wbReq.sel);
        `IDP_OFF_MODE: begin
          if (wbReq.sel[0]) begin
            multCnt_reg <= wbReq.dat[7:0];
          end
          if (wbReq.sel[1]) begin
            dmaSel_reg <= wbReq.dat[9:8];
          end
        end
        `IDP_OFF_SER0: userSer_reg[79:48] <= wbMerge(userSer_reg[79:48], wbReq.dat, wbReq.sel);
        `IDP_OFF_SER1: userSer_reg[47:16] <= wbMerge(userSer_reg[47:16], wbReq.dat, wbReq.sel);
        `IDP_OFF_SER2: userSer_reg[15:0] <= wbMerge16(userSer_reg[15:0], wbReq.dat, wbReq.sel);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // wishbone answer: ack one cycle after the strobe, unmapped reads zero
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= wbReq.cyc && wbReq.stb && !ack_reg;
      case (wbReq.adr)
        `IDP_OFF_STATUS: rdat_reg <= {14'h0000, busy, drq, 8'h00, idx_reg};
        `IDP_OFF_DEFCYL: rdat_reg <= {16'h0000, defCyl_reg};
        `IDP_OFF_DEFHEAD: rdat_reg <= {16'h0000, defHead_reg};
        `IDP_OFF_DEFSPT: rdat_reg <= {16'h0000, defSpt_reg};
        `IDP_OFF_CURCYL: rdat_reg <= {16'h0000, curCyl_reg};
        `IDP_OFF_CURHEAD: rdat_reg <= {16'h0000, curHead_reg};
        `IDP_OFF_CURSPT: rdat_reg <= {16'h0000, curSpt_reg};
        `IDP_OFF_TOTSEC: rdat_reg <= totSec_reg;
        `IDP_OFF_MODE: rdat_reg <= {22'h00_0000, dmaSel_reg, multCnt_reg};
        `IDP_OFF_SER0: rdat_reg <= userSer_reg[79:48];
        `IDP_OFF_SER1: rdat_reg <= userSer_reg[47:16];
        `IDP_OFF_SER2: rdat_reg <= {16'h0000, userSer_reg[15:0]};
        default: rdat_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign wbRsp = '{ack: ack_reg, dat: rdat_reg};

  // ---------------------------------------------------------------
  // page word contents
  // ---------------------------------------------------------------
  assign capacity = 32'(curCyl_reg * curHead_reg * curSpt_reg);

  function automatic logic [15:0] pageWord(input logic [7:0] w, input logic [7:0] sum);
    int k;
    logic [15:0] r;
    k = 0;
    r = 16'h0000;
    case (w) inside
      8'd0: r = `IDP_W_GENCFG;
      8'd1: r = defCyl_reg;
      8'd3: r = defHead_reg;
      8'd6: r = defSpt_reg;
      8'd7: r = totSec_reg[31:16];
      8'd8: r = totSec_reg[15:0];
      [8'd10:8'd14]: begin
        k = 79 - 16 * (int'(w) - 10);
        r = userSer_reg[k -: 16];
      end
      [8'd15:8'd19]: begin
        k = 79 - 16 * (int'(w) - 15);
        r = UNIQUE_ID[k -: 16];
      end
      [8'd23:8'd26]: begin
        k = 63 - 16 * (int'(w) - 23);
        r = FW_REV[k -: 16];
      end
      [8'd27:8'd46]: r = `IDP_SPACES;
      8'd47: r = `IDP_W_MULTMAX;
      8'd49: r = `IDP_W_CAPAB;
      8'd51: r = `IDP_W_PIOTIM;
      8'd53: r = `IDP_W_VALID;
      8'd54: r = curCyl_reg;
      8'd55: r = curHead_reg;
      8'd56: r = curSpt_reg;
      8'd57: r = capacity[15:0];
      8'd58: r = capacity[31:16];
      8'd59: r = {`IDP_W_MULT_VALID, multCnt_reg};
      8'd60: r = totSec_reg[15:0];
      8'd61: r = totSec_reg[31:16];
      8'd63: begin
        r = {8'h00, `IDP_W_DMA_SUPP};
        if (dmaSel_reg != 2'h0) begin
          r[7 + int'(dmaSel_reg)] = 1'b1;
        end
      end
      8'd64: r = `IDP_W_APIO;
      [8'd65:8'd68]: r = `IDP_CYCLE_NS;
      8'd80: r = `IDP_W_MAJOR;
      8'd81: r = `IDP_W_MINOR;
      8'd82: r = `IDP_W_FEAT82;
      8'd83: r = `IDP_W_FEAT83;
      8'd84: r = `IDP_W_FEAT84;
      8'd88: r = `IDP_W_UDMA;
      8'd91: r = `IDP_W_APM;
      8'd100: r = totSec_reg[15:0];
      8'd101: r = totSec_reg[31:16];
      8'd217: r = `IDP_W_ROTATE;
      8'd255: r = {8'(8'h00 - sum - `IDP_SIGNATURE), `IDP_SIGNATURE};
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // transfer sequencer: same handshake as a one-sector pio read
  // ---------------------------------------------------------------
  logic [15:0] nextWord;
  logic [7:0] nextIdx;
  assign nextIdx = (state_reg == IDP_LOAD) ? 8'h00 : 8'(idx_reg + 8'h01);
  // always_comb also wakes on the registers read inside the function
  always_comb begin
    nextWord = pageWord(nextIdx, sum_reg);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= IDP_IDLE;
      idx_reg <= 8'h00;
    end else begin
      case (state_reg)
        IDP_IDLE: begin
          if (cmdWrite && cmdCode == `IDP_CMD_IDENTIFY) begin
            state_reg <= IDP_LOAD;
          end
        end
        IDP_LOAD: begin
          state_reg <= IDP_XFER;
          idx_reg <= 8'h00;
        end
        IDP_XFER: begin
          if (dataRead) begin
            if (idx_reg == `IDP_PAGE_LAST) begin
              state_reg <= IDP_IDLE;
              idx_reg <= 8'h00;
            end else begin
              idx_reg <= nextIdx;
            end
          end
        end
        default: state_reg <= IDP_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // data register and running byte sum
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      data_reg <= 16'h0000;
      sum_reg <= 8'h00;
    end else if (state_reg == IDP_LOAD) begin
      data_reg <= nextWord;
      sum_reg <= 8'(nextWord[15:8] + nextWord[7:0]);
    end else if (state_reg == IDP_XFER && dataRead && idx_reg != `IDP_PAGE_LAST) begin
      data_reg <= nextWord;
      sum_reg <= 8'(sum_reg + nextWord[15:8] + nextWord[7:0]);
    end
  end

  assign drq = (state_reg == IDP_XFER);
  assign busy = (state_reg == IDP_LOAD);
  assign dataOut = data_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [7:0] chk_reg;
  always_ff @(posedge clk) begin
    if (reset || state_reg != IDP_XFER) begin
      chk_reg <= 8'h00;
    end else if (dataRead) begin
      chk_reg <= 8'(chk_reg + dataOut[15:8] + dataOut[7:0]);
    end
  end

  identify_start_a: assert property (@(posedge clk) disable iff (reset)
    (state_reg == IDP_IDLE && cmdWrite && cmdCode == `IDP_CMD_IDENTIFY) |-> ##1 busy ##1 drq)
    else $error("identify did not start");
  page_length_a: assert property (@(posedge clk) disable iff (reset)
    (drq && dataRead && idx_reg == `IDP_PAGE_LAST) |=> !drq)
    else $error("page did not end after word 255");
  gen_config_a: assert property (@(posedge clk) disable iff (reset)
    $rose(drq) |-> dataOut == `IDP_W_GENCFG && idx_reg == 8'h00)
    else $error("word 0 wrong");
  reserved_zero_a: assert property (@(posedge clk) disable iff (reset)
    (drq && (idx_reg == 8'd2 || idx_reg == 8'd48 || idx_reg == 8'd50
      || idx_reg == 8'd52 || idx_reg == 8'd62)) |-> dataOut == 16'h0000)
    else $error("reserved word not zero");
  fixed_words_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd47 && $changed(idx_reg)) |-> dataOut == `IDP_W_MULTMAX
      && $past(dataOut) != dataOut)
    else $error("word 47 wrong");
  capab_timing_a: assert property (@(posedge clk) disable iff (reset)
    (drq && dataRead && idx_reg == 8'd48) |=> dataOut == `IDP_W_CAPAB && idx_reg == 8'd49)
    else $error("word 49 wrong");
  valid_word_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd53) |-> dataOut == `IDP_W_VALID)
    else $error("word 53 wrong");
  udma_word_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd88) |-> dataOut == `IDP_W_UDMA)
    else $error("word 88 wrong");
  version_words_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd80) |-> dataOut == `IDP_W_MAJOR)
    else $error("word 80 wrong");
  dma_select_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd63) |-> $onehot0(dataOut[10:8]) && dataOut[7:0] == `IDP_W_DMA_SUPP
      && dataOut[15:11] == 5'h00)
    else $error("word 63 wrong");
  mult_setting_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd59) |-> dataOut == {`IDP_W_MULT_VALID, multCnt_reg})
    else $error("word 59 wrong");
  apio_cycle_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg >= 8'd65 && idx_reg <= 8'd68) |-> dataOut == `IDP_CYCLE_NS)
    else $error("cycle time word wrong");
  apio_word_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd64) |-> dataOut == `IDP_W_APIO)
    else $error("word 64 wrong");
  apm_zero_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == 8'd91) |-> dataOut == 16'h0000)
    else $error("word 91 not zero");
  checksum_sum_a: assert property (@(posedge clk) disable iff (reset)
    (drq && idx_reg == `IDP_PAGE_LAST) |-> dataOut[7:0] == `IDP_SIGNATURE
      && 8'(chk_reg + dataOut[15:8] + dataOut[7:0]) == 8'h00)
    else $error("integrity word wrong");

  identify_cmd_c: cover property (@(posedge clk) disable iff (reset)
    state_reg == IDP_IDLE && cmdWrite && cmdCode == `IDP_CMD_IDENTIFY);
  page_done_c: cover property (@(posedge clk) disable iff (reset)
    drq && dataRead && idx_reg == `IDP_PAGE_LAST);
  dma_chosen_c: cover property (@(posedge clk) disable iff (reset)
    drq && idx_reg == 8'd63 && dataOut[10]);
  slow_host_c: cover property (@(posedge clk) disable iff (reset)
    drq && !dataRead && idx_reg == 8'd100);
endmodule // idp_identify_page
`default_nettype wire

// ===== tb/idp_host_model.sv
// host-side model of the ata command and data registers
`timescale 1ns/1ps
`default_nettype none
module idp_host_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic drq,
  input wire logic [15:0] dataOut,
  // host strobes
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic dataRead
);
  logic [15:0] page [256];
  logic gotDrq;

  initial begin
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    dataRead = 1'b0;
    gotDrq = 1'b0;
  end

  // ---------------------------------------------------------------
  // command, then page read with optional stall between words
  // ---------------------------------------------------------------
  task automatic run(input logic [7:0] code, input int gap);
    int n;
    cmdWrite <= 1'b1;
    cmdCode <= code;
    @(posedge clk);
    cmdWrite <= 1'b0;
    cmdCode <= ~code;
    n = 0;
    gotDrq = 1'b0;
    while (n < 8 && !gotDrq) begin
      @(posedge clk);
      gotDrq = (drq === 1'b1);
      n++;
    end
    if (gotDrq) begin
      for (int i = 0; i < 256; i++) begin
        dataRead <= 1'b1;
        @(posedge clk);
        page[i] = dataOut;
        if (gap > 0) begin
          dataRead <= 1'b0;
          repeat (gap) @(posedge clk);
        end
      end
    end
    dataRead <= 1'b0;
  endtask
endmodule // idp_host_model
`default_nettype wire

// ===== tb/idp_identify_page_tb.sv
// self-checking bench of the identify page block
`timescale 1ns/1ps
`default_nettype none
module idp_identify_page_tb;
  import idp_pkg::*;
  localparam logic [79:0] UID = 80'h4142_4344_4546_4748_494A; // arbitrary value
  localparam logic [63:0] FWR = 64'h3031_3233_2020_2020; // arbitrary value
  logic clk;
  logic reset;
  idp_wb_req_s wbReq;
  idp_wb_rsp_s wbRsp;
  logic cmdWrite;
  logic dataRead;
  logic drq;
  logic busy;
  logic [7:0] cmdCode;
  logic [15:0] dataOut;
  logic [31:0] rd;
  int errorCnt;
  int numChecks;
  int cycles;
  logic [15:0] dCyl, dHead, dSpt, cCyl, cHead, cSpt;
  logic [31:0] tot;
  logic [7:0] mult;
  logic [1:0] dma;
  logic [79:0] user;

  idp_identify_page #(.UNIQUE_ID(UID), .FW_REV(FWR)) u_idp_identify_page (.clk(clk),
    .reset(reset), .wbReq(wbReq), .wbRsp(wbRsp), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .dataRead(dataRead), .drq(drq), .busy(busy), .dataOut(dataOut));
  idp_host_model u_idp_host_model (.clk(clk), .drq(drq), .dataOut(dataOut),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .dataRead(dataRead));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      errorCnt++;
      closeOut();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic closeOut();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] wd);
    int n;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wd};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    check(wbRsp.ack, 1'b1);
    rd = wbRsp.dat;
    wbReq <= '0;
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 4'hF, 32'h0000_0000);
    check(rd, exp);
  endtask
  function automatic logic [15:0] expWord(int i);
    logic [31:0] prod;
    prod = cCyl * cHead * cSpt;
    case (i) inside
      0: return 16'h044A;
      1: return dCyl;
      3: return dHead;
      6: return dSpt;
      7, 61, 101: return tot[31:16];
      8, 60, 100: return tot[15:0];
      [10:14]: return user[239-16*i -: 16];
      [15:19]: return UID[319-16*i -: 16];
      [23:26]: return FWR[431-16*i -: 16];
      [27:46]: return 16'h2020;
      47: return 16'h8001;
      49: return 16'h0B00;
      51: return 16'h0200;
      53: return 16'h0007;
      54: return cCyl;
      55: return cHead;
      56: return cSpt;
      57: return prod[15:0];
      58: return prod[31:16];
      59: return {8'h01, mult};
      63: return {5'h00, dma == 2'd3, dma == 2'd2, dma == 2'd1, 8'h07};
      64: return 16'h0003;
      [65:68]: return 16'h0078;
      80: return 16'h00FE;
      81: return 16'h0021;
      82: return 16'h706B;
      83: return 16'h7408;
      84: return 16'h4000;
      88: return 16'h007F;
      217: return 16'h0001;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic pageChk(input int gap);
    logic [7:0] sum;
    logic [15:0] w;
    u_idp_host_model.run(8'hEC, gap);
    check(u_idp_host_model.gotDrq, 1'b1);
    sum = 8'hA5;
    for (int i = 0; i < 255; i++) begin
      w = expWord(i);
      sum = sum + w[15:8] + w[7:0];
      check(u_idp_host_model.page[i], w);
    end
    check(u_idp_host_model.page[255], {8'h00 - sum, 8'hA5});
    @(posedge clk);
    check(drq, 1'b0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic tReset();
    check({drq, busy}, 2'b00);
    rdChk(8'h00, 32'h0000_0000);
    rdChk(8'h04, 32'h0000_0100);
    rdChk(8'h14, 32'h0000_0010);
    rdChk(8'h1C, 32'h0008_0000);
    rdChk(8'h20, 32'h0000_0000);
    rdChk(8'h24, 32'h3030_3030);
    rdChk(8'h40, 32'h0000_0000);
    pageChk(0);
  endtask
  task automatic tConfig();
    dCyl = 16'h12AB;
    dHead = 16'h000F;
    dSpt = 16'h003F;
    cCyl = 16'h0400;
    cHead = 16'h0008;
    cSpt = 16'h0011;
    tot = 32'h0123_4567;
    mult = 8'h10;
    user = 80'h4A4B_4C4D_4E4F_5051_5253;
    wb(1'b1, 8'h04, 4'hF, 32'h0000_1234);
    wb(1'b1, 8'h04, 4'b0001, 32'hFFFF_FFAB);
    rdChk(8'h04, {16'h0000, dCyl});
    wb(1'b1, 8'h08, 4'hF, {16'h0000, dHead});
    wb(1'b1, 8'h0C, 4'hF, {16'h0000, dSpt});
    wb(1'b1, 8'h10, 4'hF, {16'h0000, cCyl});
    wb(1'b1, 8'h14, 4'hF, {16'h0000, cHead});
    wb(1'b1, 8'h18, 4'hF, {16'h0000, cSpt});
    wb(1'b1, 8'h1C, 4'hF, tot);
    wb(1'b1, 8'h24, 4'hF, user[79:48]);
    wb(1'b1, 8'h28, 4'hF, user[47:16]);
    wb(1'b1, 8'h2C, 4'hF, {16'hFFFF, user[15:0]});
    for (int m = 0; m < 4; m++) begin
      dma = m[1:0];
      wb(1'b1, 8'h20, 4'hF, {22'h00_0000, dma, mult});
      pageChk(m);
    end
  endtask
  task automatic tRefuse();
    u_idp_host_model.run(8'h20, 0);
    check(u_idp_host_model.gotDrq, 1'b0);
    check(busy, 1'b0);
  endtask

  initial begin
    reset = 1'b1;
    wbReq = '0;
    errorCnt = 0;
    numChecks = 0;
    cycles = 0;
    {dCyl, cCyl} = {2{16'h0100}};
    {dHead, cHead} = {2{16'h0010}};
    {dSpt, cSpt} = {2{16'h0020}};
    tot = 32'h0008_0000;
    mult = 8'h00;
    dma = 2'd0;
    user = 80'h3030_3030_3030_3030_3030;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    tReset();
    tConfig();
    tRefuse();
    closeOut();
  end
endmodule // idp_identify_page_tb
`default_nettype wire
